// *** rtl/rsw_pkg.sv ***
// Package with register map, field layout, timing and types of the reset status and wakeup block.
package rsw_pkg;

  // Core clock rate and internal low-power oscillator period.
  localparam int CLK_MHZ = 25;
  localparam int INT_OSC_PERIOD_US = 1000;
  localparam int INT_TICK_CYCLES = INT_OSC_PERIOD_US * CLK_MHZ;

  // Byte offsets of the registers.
  localparam logic [7:0] ADDR_CAUSE = 8'h00;
  localparam logic [7:0] ADDR_WSC = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_EXT_REF = 8'h10;

  // Wakeup status and control field positions.
  localparam int WSC_FLAG_BIT = 7;
  localparam int WSC_ACK_BIT = 6;
  localparam int WSC_CLKSEL_BIT = 5;
  localparam int WSC_IE_BIT = 4;
  localparam int WSC_PER_LSB = 0;
  localparam int PER_W = 3;

  // Reset cause field positions.
  localparam int CAUSE_POR_BIT = 7;
  localparam int CAUSE_PIN_BIT = 6;
  localparam int CAUSE_WDOG_BIT = 5;
  localparam int CAUSE_OPC_BIT = 4;
  localparam int CAUSE_ADDR_BIT = 3;
  localparam int CAUSE_LOWV_BIT = 1;

  // Interrupt status and mask field positions.
  localparam int IRQ_W = 2;
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_WDCLR_BIT = 1;

  // External reference control field positions.
  localparam int EXT_CLK_EN_BIT = 0;
  localparam int EXT_STOP_EN_BIT = 1;

  // Reset values.
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  localparam logic [4:0] WSC_RESET = 5'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [1:0] EXT_RESET = 2'h0;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  // Wakeup periods in oscillator ticks for select codes 1 to 7.
  localparam logic [15:0] PER_TICKS_1 = 16'h0008;
  localparam logic [15:0] PER_TICKS_2 = 16'h0020;
  localparam logic [15:0] PER_TICKS_3 = 16'h0040;
  localparam logic [15:0] PER_TICKS_4 = 16'h0080;
  localparam logic [15:0] PER_TICKS_5 = 16'h0100;
  localparam logic [15:0] PER_TICKS_6 = 16'h0200;
  localparam logic [15:0] PER_TICKS_7 = 16'h0400;

  // Conditions present at reset entry, held stable by the reset controller until release.
  typedef struct packed {
    logic debug_cmd;
    logic por;
    logic low_volt_trip;
    logic low_voltage_reset_enable;
    logic pin_reset_n;
    logic watchdog_timeout;
    logic watchdog_enable;
    logic bad_opcode;
    logic stop_instr;
    logic stop_mode_enable;
    logic debug_halt_instr;
    logic debug_mode_enable;
    logic bad_address;
  } rsw_rst_src_t;

  // Software-written wakeup timer controls.
  typedef struct packed {
    logic clk_sel;
    logic int_en;
    logic [PER_W-1:0] period_sel;
  } rsw_wsc_t;

  function automatic logic [15:0] period_ticks(input logic [PER_W-1:0] sel);
    logic [15:0] t;
    t = 16'h0000;
    case (sel)
      3'd1: t = PER_TICKS_1;
      3'd2: t = PER_TICKS_2;
      3'd3: t = PER_TICKS_3;
      3'd4: t = PER_TICKS_4;
      3'd5: t = PER_TICKS_5;
      3'd6: t = PER_TICKS_6;
      3'd7: t = PER_TICKS_7;
      default: t = 16'h0000;
    endcase
    return t;
  endfunction : period_ticks

endpackage : rsw_pkg

// *** rtl/rsw_wakeup_timer.sv ***
// Periodic wakeup counter with sticky wakeup flag.
`timescale 1ns/1ns
module rsw_wakeup_timer (
  // Clock and synchronised reset.
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Selected oscillator tick and controls.
  input wire logic tick_i,
  input wire logic [rsw_pkg::PER_W-1:0] period_sel_i,
  input wire logic ack_i,
  // Flag and one-cycle event.
  output logic flag_o,
  output logic event_o
);

  logic [15:0] cnt_reg;
  logic [rsw_pkg::PER_W-1:0] sel_q_reg;
  logic [15:0] last_tick;
  logic hit;

  assign last_tick = rsw_pkg::period_ticks(period_sel_i) - 16'h0001;
  assign hit = tick_i && (period_sel_i != 3'd0) && (cnt_reg == last_tick);

  // A change of period restarts the count so the new period is whole.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= rsw_pkg::CNT_RESET;
      sel_q_reg <= 3'd0;
    end else begin
      sel_q_reg <= period_sel_i;
      if (period_sel_i == 3'd0 || period_sel_i != sel_q_reg) begin
        cnt_reg <= rsw_pkg::CNT_RESET;
      end else if (hit) begin
        cnt_reg <= rsw_pkg::CNT_RESET;
      end else if (tick_i) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_o <= 1'b0;
    end else begin
      event_o <= hit && (period_sel_i == sel_q_reg);
    end
  end

  // Setting wins over an acknowledge in the same cycle.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else if (event_o) begin
      flag_o <= 1'b1;
    end else if (ack_i) begin
      flag_o <= 1'b0;
    end
  end

  a_disabled_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (period_sel_i == 3'd0) |=> !event_o)
    else $error("wakeup event while timer disabled");

  a_flag_sets: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    event_o |=> flag_o)
    else $error("wakeup flag not set after event");

  a_ack_clears: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (ack_i && !event_o) |=> !flag_o)
    else $error("acknowledge did not clear wakeup flag");

endmodule : rsw_wakeup_timer

// *** rtl/rsw_top.sv ***
// Reset cause register, periodic wakeup timer control and Avalon-MM register slave.
//
// How it works
// - Wakeup timer ticks from internal 1 kHz oscillator or external reference, by select bit.
// - Timer keeps counting in run, wait and stop mode from the internal oscillator; external ticks in stop mode need the stop enable bit.
// - Control register holds read-only flag, write-only acknowledge and 3-bit period.
// - Local interrupt enable masks the wakeup interrupt request.
// - Period select of zero disables the timer and stops new wakeup events; a flag already set stays set and keeps requesting.
// - Reset cause flags are read-only; software writes never change them.
// - Debug host forced reset leaves all reset cause flags cleared.
// - Any write to reset cause address pulses watchdog clear; contents unchanged.
// - Power-on reset sets bits 7 and 1 and clears the rest.
// - Bit 1 set by low-voltage trip with reset enabled, or by power-on.
// - Other resets set flags of active sources; power-on and low-voltage read zero.
// - Bit 6 set when the external reset pin caused the reset.
// - Bit 5 set by watchdog timeout; cleared watchdog enable blocks it.
// - Bit 4 set by illegal opcode, including disabled stop or debug halt.
// - Bit 3 set by access to an unimplemented address.
`timescale 1ns/1ns
module rsw_top #(
  parameter int INT_TICK_CYCLES = rsw_pkg::INT_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Reset entry conditions and operating mode.
  input wire rsw_pkg::rsw_rst_src_t rst_src_i,
  input wire logic stop_mode_i,
  // External reference clock, sampled; each rising edge gives one tick.
  input wire logic ext_ref_clk_i,
  // Outputs to the clock and watchdog logic.
  output logic ext_ref_clock_enable_o,
  output logic ext_ref_stop_enable_o,
  output logic watchdog_clear_o,
  // Interrupts.
  output logic wakeup_irq_o,
  output logic irq_o
);

  logic rst_s1_reg;
  logic rst_n_q;
  logic [15:0] div_reg;
  logic int_tick;
  logic ext_q_reg;
  logic ext_edge;
  logic ext_ok;
  logic tick_sel;
  rsw_pkg::rsw_wsc_t wsc_reg;
  logic [1:0] ext_reg;
  logic [7:0] cause_reg;
  logic cap_pend_reg;
  logic [rsw_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [rsw_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [rsw_pkg::IRQ_W-1:0] irq_set;
  logic [rsw_pkg::IRQ_W-1:0] irq_w1c;
  logic wr_acc;
  logic rd_acc;
  logic req_new;
  logic lane0;
  logic ack_pulse;
  logic tmr_flag;
  logic tmr_event;
  logic [31:0] rdata_mux;

  function automatic logic [7:0] cause_of(input rsw_pkg::rsw_rst_src_t s);
    logic [7:0] c;
    c = rsw_pkg::CAUSE_RESET;
    if (s.debug_cmd) begin
      c = rsw_pkg::CAUSE_RESET;
    end else if (s.por) begin
      c[rsw_pkg::CAUSE_POR_BIT] = 1'b1;
      c[rsw_pkg::CAUSE_LOWV_BIT] = 1'b1;
    end else if (s.low_volt_trip && s.low_voltage_reset_enable) begin
      c[rsw_pkg::CAUSE_LOWV_BIT] = 1'b1;
    end else begin
      c[rsw_pkg::CAUSE_PIN_BIT] = !s.pin_reset_n;
      c[rsw_pkg::CAUSE_WDOG_BIT] = s.watchdog_timeout && s.watchdog_enable;
      c[rsw_pkg::CAUSE_OPC_BIT] = s.bad_opcode
        || (s.stop_instr && !s.stop_mode_enable)
        || (s.debug_halt_instr && !s.debug_mode_enable);
      c[rsw_pkg::CAUSE_ADDR_BIT] = s.bad_address;
    end
    return c;
  endfunction : cause_of

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction : hit

  // Reset release through two flip-flops.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_q <= rst_s1_reg;
    end
  end

  // Internal 1 kHz oscillator tick from the core clock.
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_reg <= rsw_pkg::CNT_RESET;
    end else if (div_reg == 16'(INT_TICK_CYCLES - 1)) begin
      div_reg <= rsw_pkg::CNT_RESET;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end
  assign int_tick = (div_reg == 16'(INT_TICK_CYCLES - 1));

  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ext_q_reg <= 1'b0;
    end else begin
      ext_q_reg <= ext_ref_clk_i;
    end
  end
  assign ext_edge = ext_ref_clk_i && !ext_q_reg;

  // Mode only gates the external source through its enables; the counter never halts.
  assign ext_ok = ext_reg[rsw_pkg::EXT_CLK_EN_BIT]
    && (!stop_mode_i || ext_reg[rsw_pkg::EXT_STOP_EN_BIT]);
  assign tick_sel = wsc_reg.clk_sel ? (ext_edge && ext_ok) : int_tick;

  rsw_wakeup_timer u_timer (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_q),
    .tick_i(tick_sel),
    .period_sel_i(wsc_reg.period_sel),
    .ack_i(ack_pulse),
    .flag_o(tmr_flag),
    .event_o(tmr_event)
  );

  // Every request waits one cycle, then is answered with waitrequest low for one cycle.
  assign req_new = (avs_read_i || avs_write_i) && avs_waitrequest_o;
  assign wr_acc = avs_write_i && !avs_waitrequest_o;
  assign rd_acc = avs_read_i && !avs_waitrequest_o;
  assign lane0 = avs_byteenable_i[0];

  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !req_new;
    end
  end

  always_comb begin
    rdata_mux = 32'h0000_0000;
    if (hit(avs_address_i, rsw_pkg::ADDR_CAUSE)) begin
      rdata_mux[7:0] = cause_reg;
    end else if (hit(avs_address_i, rsw_pkg::ADDR_WSC)) begin
      rdata_mux[rsw_pkg::WSC_FLAG_BIT] = tmr_flag;
      rdata_mux[rsw_pkg::WSC_ACK_BIT] = 1'b0;
      rdata_mux[rsw_pkg::WSC_CLKSEL_BIT] = wsc_reg.clk_sel;
      rdata_mux[rsw_pkg::WSC_IE_BIT] = wsc_reg.int_en;
      rdata_mux[rsw_pkg::WSC_PER_LSB +: rsw_pkg::PER_W] = wsc_reg.period_sel;
    end else if (hit(avs_address_i, rsw_pkg::ADDR_IRQ_STAT)) begin
      rdata_mux[rsw_pkg::IRQ_W-1:0] = irq_stat_reg;
    end else if (hit(avs_address_i, rsw_pkg::ADDR_IRQ_MASK)) begin
      rdata_mux[rsw_pkg::IRQ_W-1:0] = irq_mask_reg;
    end else if (hit(avs_address_i, rsw_pkg::ADDR_EXT_REF)) begin
      rdata_mux[1:0] = ext_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (req_new && avs_read_i) begin
      avs_readdata_o <= rdata_mux;
    end
  end

  // Wakeup control register.
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wsc_reg <= rsw_pkg::WSC_RESET;
    end else if (wr_acc && lane0 && hit(avs_address_i, rsw_pkg::ADDR_WSC)) begin
      wsc_reg.clk_sel <= avs_writedata_i[rsw_pkg::WSC_CLKSEL_BIT];
      wsc_reg.int_en <= avs_writedata_i[rsw_pkg::WSC_IE_BIT];
      wsc_reg.period_sel <= avs_writedata_i[rsw_pkg::WSC_PER_LSB +: rsw_pkg::PER_W];
    end
  end
  assign ack_pulse = wr_acc && lane0 && hit(avs_address_i, rsw_pkg::ADDR_WSC)
    && avs_writedata_i[rsw_pkg::WSC_ACK_BIT];

  // External reference enables.
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ext_reg <= rsw_pkg::EXT_RESET;
    end else if (wr_acc && lane0 && hit(avs_address_i, rsw_pkg::ADDR_EXT_REF)) begin
      ext_reg <= avs_writedata_i[1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ext_ref_clock_enable_o <= 1'b0;
      ext_ref_stop_enable_o <= 1'b0;
    end else begin
      ext_ref_clock_enable_o <= ext_reg[rsw_pkg::EXT_CLK_EN_BIT];
      ext_ref_stop_enable_o <= ext_reg[rsw_pkg::EXT_STOP_EN_BIT];
    end
  end

  // Reset cause is captured once, at the first edge after release, and never written.
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cap_pend_reg <= 1'b1;
      cause_reg <= rsw_pkg::CAUSE_RESET;
    end else if (cap_pend_reg) begin
      cap_pend_reg <= 1'b0;
      cause_reg <= cause_of(rst_src_i);
    end
  end

  // A write to the cause address, any data and lanes, clears the watchdog.
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      watchdog_clear_o <= 1'b0;
    end else begin
      watchdog_clear_o <= wr_acc && hit(avs_address_i, rsw_pkg::ADDR_CAUSE);
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear.
  assign irq_set[rsw_pkg::IRQ_WAKE_BIT] = tmr_event && wsc_reg.int_en;
  assign irq_set[rsw_pkg::IRQ_WDCLR_BIT] = watchdog_clear_o;
  assign irq_w1c = (wr_acc && lane0 && hit(avs_address_i, rsw_pkg::ADDR_IRQ_STAT))
    ? avs_writedata_i[rsw_pkg::IRQ_W-1:0] : 2'b00;

  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_stat_reg <= rsw_pkg::IRQ_RESET;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_w1c) | irq_set;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_mask_reg <= rsw_pkg::IRQ_RESET;
    end else if (wr_acc && lane0 && hit(avs_address_i, rsw_pkg::ADDR_IRQ_MASK)) begin
      irq_mask_reg <= avs_writedata_i[rsw_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_o <= 1'b0;
      wakeup_irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_reg & irq_mask_reg);
      wakeup_irq_o <= tmr_flag && wsc_reg.int_en;
    end
  end

  // Checks.
  sequence s_cause_write;
    wr_acc && hit(avs_address_i, rsw_pkg::ADDR_CAUSE);
  endsequence

  sequence s_clear_pulse;
    watchdog_clear_o ##1 !watchdog_clear_o;
  endsequence

  sequence s_capture_other;
    cap_pend_reg && !rst_src_i.debug_cmd && !rst_src_i.por
      && !(rst_src_i.low_volt_trip && rst_src_i.low_voltage_reset_enable);
  endsequence

  a_cause_readonly: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    (!cap_pend_reg and s_cause_write) |=> $stable(cause_reg))
    else $error("reset cause changed by software write");

  a_wdog_clear_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    s_cause_write |=> s_clear_pulse)
    else $error("watchdog clear pulse missing or too long");

  a_debug_clears: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    (cap_pend_reg && rst_src_i.debug_cmd) |=> (cause_reg == 8'h00))
    else $error("debug forced reset left a cause flag set");

  a_por_pattern: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    (cap_pend_reg && !rst_src_i.debug_cmd && rst_src_i.por) |=> (cause_reg == 8'h82))
    else $error("power-on cause pattern wrong");

  a_lowv_pattern: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    (cap_pend_reg && !rst_src_i.debug_cmd && !rst_src_i.por && rst_src_i.low_volt_trip
      && rst_src_i.low_voltage_reset_enable) |=> (cause_reg == 8'h02))
    else $error("low-voltage cause pattern wrong");

  a_other_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    s_capture_other |=> (!cause_reg[7] && !cause_reg[1]))
    else $error("power-on or low-voltage flag set on other reset");

  a_pin_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    s_capture_other |=> (cause_reg[6] == !$past(rst_src_i.pin_reset_n)))
    else $error("pin reset flag wrong");

  a_wdog_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    s_capture_other |=> (cause_reg[5]
      == $past(rst_src_i.watchdog_timeout && rst_src_i.watchdog_enable)))
    else $error("watchdog cause flag wrong");

  a_opcode_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    (s_capture_other and (rst_src_i.stop_instr && !rst_src_i.stop_mode_enable))
      |=> cause_reg[4])
    else $error("illegal stop did not set opcode flag");

  a_address_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    s_capture_other |=> (cause_reg[3] == $past(rst_src_i.bad_address)))
    else $error("illegal address flag wrong");

  a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    (!cause_reg[2] && !cause_reg[0]))
    else $error("reserved reset cause bit set");

  a_irq_gated: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    (!irq_stat_reg[0] && !wsc_reg.int_en) |=> !irq_stat_reg[0])
    else $error("masked wakeup set interrupt status");

  a_ack_reads_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    (rd_acc && hit(avs_address_i, rsw_pkg::ADDR_WSC)) |-> !avs_readdata_o[6])
    else $error("acknowledge bit read back as one");

  a_clock_select: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
    (!wsc_reg.clk_sel && tick_sel) |-> int_tick)
    else $error("wakeup tick not from internal oscillator");

endmodule : rsw_top

// *** test/testbench.sv ***
// Self-checking testbench for the reset cause and periodic wakeup block.
`timescale 1ns/1ns
module testbench;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat;
  logic wait_req;
  rsw_pkg::rsw_rst_src_t src = 13'h010A;
  logic stop_mode = 1'b0;
  logic ext_clk = 1'b0;
  logic ext_en;
  logic ext_stop;
  logic wd_clr;
  logic wake_irq;
  logic irq;
  int bad_count = 0;
  int n_tests = 0;
  logic [31:0] q;
  // Idle sources: pin high, stop and debug enabled; each entry sets up one cause, except the second (debug over power-on), the last (pin and address)
  // and the fourth, seventh and tenth, which set up a blocked low-voltage trip, watchdog timeout and stop and expect no flag.
  logic [12:0] src_tab [13] = '{13'h090A, 13'h190A, 13'h070A, 13'h050A, 13'h000A, 13'h01CA,
    13'h018A, 13'h012A, 13'h0112, 13'h011A, 13'h010C, 13'h010B, 13'h000B};
  logic [7:0] exp_tab [13] = '{8'h82, 8'h00, 8'h02, 8'h00, 8'h40, 8'h20,
    8'h00, 8'h10, 8'h10, 8'h00, 8'h10, 8'h08, 8'h48};

  rsw_top #(.INT_TICK_CYCLES(10)) i_rsw_top (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_req),
    .rst_src_i(src), .stop_mode_i(stop_mode), .ext_ref_clk_i(ext_clk),
    .ext_ref_clock_enable_o(ext_en), .ext_ref_stop_enable_o(ext_stop),
    .watchdog_clear_o(wd_clr), .wakeup_irq_o(wake_irq), .irq_o(irq)
  );

  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end

  task automatic finish_test;
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One Avalon transfer, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      bad_count++;
    end
  endtask : bus

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask : rd_chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cyc

  task automatic ext_ticks(input int n);
    repeat (n) begin
      ext_clk <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      ext_clk <= 1'b0;
      repeat (2) @(posedge core_clk_i);
    end
  endtask : ext_ticks

  initial begin
    repeat (20000) @(posedge core_clk_i);
    bad_count++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    cyc(4);
    rd_chk(rsw_pkg::ADDR_CAUSE, 32'h0000_0000);
    rd_chk(rsw_pkg::ADDR_WSC, 32'h0000_0000);
    rd_chk(rsw_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    rd_chk(rsw_pkg::ADDR_EXT_REF, 32'h0000_0000);
    rd_chk(8'h14, 32'h0000_0000);
    for (int i = 0; i < 13; i++) begin
      @(posedge core_clk_i);
      src <= src_tab[i];
      rst_n_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      cyc(4);
      rd_chk(rsw_pkg::ADDR_CAUSE, {24'h00_0000, exp_tab[i]});
    end
    wr_reg(rsw_pkg::ADDR_CAUSE, 32'h0000_00FF);
    #1;
    check(wd_clr, 1'b1);
    rd_chk(rsw_pkg::ADDR_CAUSE, 32'h0000_0048);
    rd_chk(rsw_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
    wr_reg(rsw_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
    rd_chk(rsw_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    // Internal oscillator, period code 1 is 8 ticks of 10 cycles.
    wr_reg(rsw_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    wr_reg(rsw_pkg::ADDR_WSC, 32'h0000_0011);
    cyc(55);
    rd_chk(rsw_pkg::ADDR_WSC, 32'h0000_0011);
    cyc(50);
    rd_chk(rsw_pkg::ADDR_WSC, 32'h0000_0091);
    check(wake_irq, 1'b1);
    check(irq, 1'b1);
    wr_reg(rsw_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
    cyc(3);
    check(irq, 1'b0);
    wr_reg(rsw_pkg::ADDR_WSC, 32'h0000_0051);
    rd_chk(rsw_pkg::ADDR_WSC, 32'h0000_0011);
    check(wake_irq, 1'b0);
    wr_reg(rsw_pkg::ADDR_WSC, 32'h0000_0001);
    cyc(100);
    rd_chk(rsw_pkg::ADDR_WSC, 32'h0000_0081);
    check(wake_irq, 1'b0);
    rd_chk(rsw_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    // Keep the acknowledge clear of the edge at which the next period sets the flag.
    cyc(5);
    wr_reg(rsw_pkg::ADDR_WSC, 32'h0000_0050);
    cyc(200);
    rd_chk(rsw_pkg::ADDR_WSC, 32'h0000_0010);
    check(wake_irq, 1'b0);
    // External reference: blocked until enabled, then 8 ticks per period.
    wr_reg(rsw_pkg::ADDR_WSC, 32'h0000_0031);
    ext_ticks(10);
    rd_chk(rsw_pkg::ADDR_WSC, 32'h0000_0031);
    wr_reg(rsw_pkg::ADDR_EXT_REF, 32'h0000_0001);
    cyc(2);
    check(ext_en, 1'b1);
    wr_reg(rsw_pkg::ADDR_WSC, 32'h0000_0031);
    ext_ticks(6);
    rd_chk(rsw_pkg::ADDR_WSC, 32'h0000_0031);
    ext_ticks(3);
    rd_chk(rsw_pkg::ADDR_WSC, 32'h0000_00B1);
    wr_reg(rsw_pkg::ADDR_WSC, 32'h0000_0071);
    stop_mode <= 1'b1;
    ext_ticks(10);
    rd_chk(rsw_pkg::ADDR_WSC, 32'h0000_0031);
    wr_reg(rsw_pkg::ADDR_EXT_REF, 32'h0000_0003);
    cyc(2);
    check(ext_stop, 1'b1);
    wr_reg(rsw_pkg::ADDR_WSC, 32'h0000_0031);
    ext_ticks(9);
    rd_chk(rsw_pkg::ADDR_WSC, 32'h0000_00B1);
    be <= 4'h0;
    wr_reg(rsw_pkg::ADDR_EXT_REF, 32'h0000_0000);
    be <= 4'hF;
    rd_chk(rsw_pkg::ADDR_EXT_REF, 32'h0000_0003);
    finish_test();
  end
endmodule : testbench
